// *** core/lane_pkg.sv ***
package lane_pkg;

	// ********************************************************************
	// Bus geometry and register map
	// ********************************************************************
	localparam int          ADDR_W   = 8;
	localparam int          DATA_W   = 32;
	localparam logic [7:0]  CTRL_OFS = 8'h00;
	localparam logic [7:0]  STAT_OFS = 8'h04;
	localparam logic [7:0]  WORD_OFS = 8'h08;

	// ********************************************************************
	// Control register fields
	// ********************************************************************
	localparam int          FACTOR_POS  = 0;
	localparam int          HALF_POS    = 4;
	localparam int          DPA_POS     = 5;
	localparam int          QUEUE_POS   = 6;
	localparam int          MODE_POS    = 7;
	localparam int          DIR_TX_POS  = 9;
	localparam int          LOW_POS     = 10;
	localparam int          DYN_POS     = 11;
	localparam int          TERM_POS    = 12;
	localparam int          LANES_POS   = 13;
	localparam logic [31:0] CTRL_RST    = 32'h0000_2008;

	// ********************************************************************
	// Status register fields
	// ********************************************************************
	localparam int          LOCK_POS    = 0;
	localparam int          EMPTY_POS   = 1;
	localparam int          OVF_POS     = 2;
	localparam int          CFGERR_POS  = 3;
	localparam int          RATEOK_POS  = 4;
	localparam int          TAP_POS     = 8;
	localparam int          DPATAP_POS  = 16;

	// ********************************************************************
	// Fixed figures
	// ********************************************************************
	localparam logic [3:0]  FACTOR_MAX    = 4'hA;
	localparam logic [3:0]  LANE_FACTOR   = 4'h8;
	localparam logic [2:0]  CLK_BIT_LAST  = 3'h7;
	localparam int          CLK_MHZ       = 10;
	localparam int          LANE_MAX_MBPS = 1500;

	typedef enum logic [1:0] {
		SERDES_BIDIR,
		LANE_DATA_BIDIR,
		LANE_DATA_UNI,
		LANE_CLOCK
	} lane_mode_e;

endpackage

// *** core/lane_core.sv ***
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// R1: Bidirectional lane uses one shared serialization factor for both directions.
// R2: Receive words of programmable width up to ten bits, on word clock.
// R3: With phase alignment on, lock output rises once training has settled.
// R4: With queue on, queue-empty output is high whenever the queue holds nothing.
// R5: Fabric pops queue entries with the pop input on the read clock.
// R6: Receive-side clear empties the queue and the deserializer.
// R7: Clear belongs to queue read clock with queue on, else word clock.
// R8: Input buffer runs while buffer-on is 1, powered down while 0.
// R9: In dynamic termination mode termination follows the termination input.
// R10: Tap-adjust enable, taken on word clock, drives delay or phase alignment.
// R11: Tap adjust steps delay up on 1, down on 0; not under alignment.
// R12: Tap clear, taken on word clock, resets delay counter or alignment.
// R13: Fabric supplies transmit words up to ten bits on the word clock.
// R14: Transmit-side clear, taken on transmit word clock, resets the serializer.
// R15: Camera/display high-rate lanes serialize and deserialize by eight.
// R16: Low-energy mode passes pad levels straight through, no deserializer.
// R17: Camera/display lane bit rate is limited to 1.5 Gbps.
// R18: Cell works as bidirectional data, unidirectional data or clock lane.
// R19: Receive clock lane divides incoming bit clock and forwards both clocks.
// R20: Data lane clocks come from its own group's clock lane. Here only the receive side uses them; transmit runs on local enables.
// R21: A link has one clock lane and 1, 2, 4 or 8 data lanes.
// R22: Receive clock lane only on the dedicated cell; transmit on any.
// R23: Word clock equals serial rate over serialization factor.
// R24: Half rate samples both bit clock edges, full rate rising only.
// R25: Receive words leave aligned, updated at the word clock.
// R26: Transmit words are captured at the transmit word clock.
// R27: Pads are driven only while pad-drive enable is high.
module lane_core #(
	parameter int BIT_DIV       = 2,
	parameter int QUEUE_DEPTH   = 4,
	parameter int TAP_MAX       = 31,
	parameter int LOCK_WORDS    = 16,
	parameter bit IS_CLOCK_CELL = 1'b1
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// Register port
	input  wire logic [lane_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [lane_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [lane_pkg::DATA_W-1:0] reg_rdata,
	// Receive fabric side
	output logic      [9:0]                  rx_word,
	output logic                             rx_word_valid,
	output logic                             lock,
	output logic                             queue_empty,
	input  wire logic                        queue_pop,
	input  wire logic                        rx_side_clear,
	input  wire logic                        rx_buffer_on,
	input  wire logic                        term_ctrl,
	input  wire logic                        tap_adjust_on,
	input  wire logic                        tap_up_down,
	input  wire logic                        tap_clear,
	// Transmit fabric side
	input  wire logic [9:0]                  tx_word,
	output logic                             tx_word_taken,
	input  wire logic                        tx_side_clear,
	input  wire logic                        pad_drive_on,
	// Low-energy levels
	input  wire logic                        low_p_out,
	input  wire logic                        low_n_out,
	output logic                             low_p_in,
	output logic                             low_n_in,
	// Lane clock distribution
	input  wire logic                        fwd_bit_tick,
	input  wire logic                        fwd_word_tick,
	output logic                             lane_bit_clock,
	output logic                             lane_word_clock,
	// Pads
	input  wire logic                        pad_p_i,
	input  wire logic                        pad_n_i,
	output logic                             pad_p_o,
	output logic                             pad_n_o,
	output logic                             pad_oe,
	output logic                             pad_rx_on,
	output logic                             pad_term_on
);
	import lane_pkg::*;

	localparam int         TAP_W = $clog2(TAP_MAX + 1);
	localparam int         QW    = $clog2(QUEUE_DEPTH);
	localparam int         CW    = $clog2(QUEUE_DEPTH + 1);
	localparam int         GW    = $clog2(LOCK_WORDS + 1);
	localparam logic [7:0] BD_LAST  = 8'(BIT_DIV - 1);
	localparam logic [TAP_W-1:0] TAP_LAST = TAP_W'(TAP_MAX);
	localparam logic [GW-1:0]    GOOD_LAST = GW'(LOCK_WORDS - 1);
	localparam logic [CW-1:0]    Q_FULL    = CW'(QUEUE_DEPTH);

	// ********************************************************************
	// Helpers
	// ********************************************************************
	function automatic logic [9:0] width_mask(input logic [3:0] f);
		for (int i = 0; i < 10; i++) begin
			width_mask[i] = (4'(i) < f);
		end
	endfunction

	function automatic logic [3:0] eff_factor(input logic [3:0] raw, input logic lane);
		if (lane) begin
			eff_factor = LANE_FACTOR;
		end else if (raw == 4'h0) begin
			eff_factor = 4'h1;
		end else if (raw > FACTOR_MAX) begin
			eff_factor = FACTOR_MAX;
		end else begin
			eff_factor = raw;
		end
	endfunction

	// ********************************************************************
	// Configuration decode
	// ********************************************************************
	logic [31:0]    ctrl_r;
	logic [31:0]    stat_w;
	logic           ovf_r;
	lane_mode_e     mode;
	logic           lane_on;
	logic           uni;
	logic           tx_side;
	logic           rx_side;
	logic           clk_lane;
	logic           low_on;
	logic           half;
	logic           dpa_en;
	logic           queue_en;
	logic [3:0]     factor;
	logic [3:0]     lanes;
	logic [9:0]     mask;
	logic           cfg_err;
	logic           rate_ok;

	assign mode     = lane_mode_e'(ctrl_r[MODE_POS +: 2]);
	assign lane_on  = (mode != SERDES_BIDIR);
	assign uni      = (mode == LANE_DATA_UNI) || (mode == LANE_CLOCK); // [R18]
	assign tx_side  = !uni || ctrl_r[DIR_TX_POS];
	assign rx_side  = !uni || !ctrl_r[DIR_TX_POS];
	assign clk_lane = (mode == LANE_CLOCK);
	assign low_on   = lane_on && ctrl_r[LOW_POS];
	assign half     = ctrl_r[HALF_POS];
	assign dpa_en   = ctrl_r[DPA_POS];
	assign queue_en = ctrl_r[QUEUE_POS];
	assign lanes    = ctrl_r[LANES_POS +: 4];
	// One factor field serves both directions, so they cannot disagree.
	assign factor   = eff_factor(ctrl_r[FACTOR_POS +: 4], lane_on); // [R1] [R15]
	assign mask     = width_mask(factor);
	assign cfg_err  = (clk_lane && rx_side && !IS_CLOCK_CELL) // [R22]
		|| !(lanes == 4'h1 || lanes == 4'h2 || lanes == 4'h4 || lanes == 4'h8); // [R21]
	assign rate_ok  = ((CLK_MHZ / BIT_DIV) <= LANE_MAX_MBPS); // [R17]

	// ********************************************************************
	// Local bit and word enables
	// ********************************************************************
	logic [7:0]     bdiv_r;
	logic [3:0]     tbit_r;
	logic           bit_tick;
	logic           loc_word;

	assign bit_tick = (bdiv_r == BD_LAST);
	assign loc_word = bit_tick && (tbit_r == factor - 4'h1); // [R23]

	always_ff @(posedge clk) begin
		if (rst || bit_tick) begin
			bdiv_r <= 8'h00;
		end else begin
			bdiv_r <= bdiv_r + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tbit_r <= 4'h0;
		end else if (loc_word) begin
			tbit_r <= 4'h0;
		end else if (bit_tick) begin
			tbit_r <= tbit_r + 4'h1;
		end
	end

	// ********************************************************************
	// Receive input, delay line and clock-lane recovery
	// ********************************************************************
	logic               rx_in;
	logic               prev_r;
	logic               edge_bit;
	logic [2:0]         cbit_r;
	logic               cword;
	logic [TAP_MAX+1:0] dly_r;
	logic [TAP_W-1:0]   tap_r;
	logic [TAP_W-1:0]   dpa_tap_r;
	logic [TAP_W-1:0]   idx;
	logic               rx_bit;
	logic               rx_bit_t;
	logic               rx_word_t;

	// With the buffer off the receiver sees a steady zero.
	assign rx_in    = pad_rx_on && pad_p_i && !pad_n_i; // [R8]
	assign edge_bit = half ? (rx_in ^ prev_r) : (rx_in && !prev_r); // [R24]
	assign cword    = edge_bit && (cbit_r == CLK_BIT_LAST); // [R19]
	assign idx      = dpa_en ? dpa_tap_r : tap_r;
	assign rx_bit   = dly_r[idx];
	// Data lanes of a camera/display group receive on the clocks of their clock lane; transmit keeps the local enables.
	assign rx_bit_t  = (lane_on && !clk_lane) ? fwd_bit_tick : bit_tick; // [R20]
	assign rx_word_t = (lane_on && !clk_lane) ? fwd_word_tick : loc_word; // [R20]

	always_ff @(posedge clk) begin
		if (rst) begin
			prev_r <= 1'b0;
			dly_r  <= '0;
		end else begin
			prev_r <= rx_in;
			dly_r  <= {dly_r[TAP_MAX:0], rx_in};
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !clk_lane) begin
			cbit_r <= 3'h0;
		end else if (edge_bit) begin
			cbit_r <= cbit_r + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lane_bit_clock  <= 1'b0;
			lane_word_clock <= 1'b0;
		end else begin
			lane_bit_clock  <= clk_lane && rx_side && edge_bit; // [R19]
			lane_word_clock <= clk_lane && rx_side && cword; // [R19]
		end
	end

	// ********************************************************************
	// Tap control and phase alignment
	// ********************************************************************
	logic           edge_seen_r;
	logic           edge_now;
	logic [GW-1:0]  good_r;

	assign edge_now = rx_bit_t && (dly_r[idx] != dly_r[idx + 1]);

	always_ff @(posedge clk) begin
		if (rst) begin
			tap_r <= '0;
		end else if (rx_word_t && tap_clear && !dpa_en) begin
			tap_r <= '0; // [R12]
		end else if (rx_word_t && tap_adjust_on && !dpa_en) begin // [R10]
			if (tap_up_down && tap_r != TAP_LAST) begin
				tap_r <= tap_r + 1'b1; // [R11]
			end else if (!tap_up_down && tap_r != '0) begin
				tap_r <= tap_r - 1'b1; // [R11]
			end
		end
	end

	// A transition right at the sample point means the phase sits on an edge.
	always_ff @(posedge clk) begin
		if (rst || (rx_word_t && !edge_now)) begin
			edge_seen_r <= 1'b0;
		end else if (edge_now) begin
			edge_seen_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !dpa_en) begin
			dpa_tap_r <= '0;
			good_r    <= '0;
			lock      <= 1'b0;
		end else if (rx_word_t && tap_clear) begin
			dpa_tap_r <= '0; // [R12]
			good_r    <= '0;
			lock      <= 1'b0;
		end else if (rx_word_t && tap_adjust_on && !lock) begin // [R10]
			if (edge_seen_r || edge_now) begin
				dpa_tap_r <= (dpa_tap_r == TAP_LAST) ? '0 : dpa_tap_r + 1'b1;
				good_r    <= '0;
			end else if (good_r == GOOD_LAST) begin
				lock <= 1'b1; // [R3]
			end else begin
				good_r <= good_r + 1'b1;
			end
		end
	end

	// ********************************************************************
	// Deserializer and receive queue
	// ********************************************************************
	logic [9:0]     sh_r;
	logic [9:0]     wd_nxt;
	logic [9:0]     last_r;
	logic           rx_clr;
	logic           push;
	logic           push_ok;
	logic           pop_ok;
	logic [9:0]     mem [QUEUE_DEPTH];
	logic [QW-1:0]  wp_r;
	logic [QW-1:0]  rp_r;
	logic [CW-1:0]  cnt_r;
	logic [CW-1:0]  cnt_nxt;

	assign wd_nxt = {sh_r[8:0], rx_bit} & mask; // [R2] [R25]
	// The clear acts at once on the queue side, else at the next word edge.
	assign rx_clr  = rx_side_clear && (queue_en || rx_word_t); // [R6] [R7]
	assign push    = rx_word_t && rx_side && !low_on && !clk_lane; // [R16]
	assign push_ok = queue_en && push && (cnt_r != Q_FULL);
	assign pop_ok  = queue_en && queue_pop && (cnt_r != '0); // [R5]
	assign cnt_nxt = cnt_r + CW'(push_ok) - CW'(pop_ok);

	always_ff @(posedge clk) begin
		if (rst || rx_clr) begin
			sh_r   <= 10'h000; // [R6]
			last_r <= 10'h000;
		end else begin
			if (rx_bit_t) begin
				sh_r <= {sh_r[8:0], rx_bit};
			end
			if (push) begin
				last_r <= wd_nxt;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push_ok) begin
			mem[wp_r] <= wd_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || rx_clr) begin
			wp_r        <= '0; // [R6]
			rp_r        <= '0;
			cnt_r       <= '0;
			queue_empty <= 1'b1;
		end else begin
			wp_r        <= wp_r + QW'(push_ok);
			rp_r        <= rp_r + QW'(pop_ok);
			cnt_r       <= cnt_nxt;
			queue_empty <= (cnt_nxt == '0); // [R4]
		end
	end

	always_ff @(posedge clk) begin
		if (rst || rx_clr) begin
			rx_word       <= 10'h000;
			rx_word_valid <= 1'b0;
		end else if (queue_en) begin
			rx_word_valid <= pop_ok;
			if (pop_ok) begin
				rx_word <= mem[rp_r]; // [R5]
			end
		end else begin
			rx_word_valid <= push;
			if (push) begin
				rx_word <= wd_nxt; // [R25]
			end
		end
	end

	// Overflow is sticky; a new one beats a software clear in the same cycle.
	always_ff @(posedge clk) begin
		if (rst) begin
			ovf_r <= 1'b0;
		end else if (queue_en && push && !push_ok) begin
			ovf_r <= 1'b1;
		end else if (reg_wr && reg_addr == STAT_OFS && reg_wdata[OVF_POS]) begin
			ovf_r <= 1'b0;
		end
	end

	// ********************************************************************
	// Serializer and pads
	// ********************************************************************
	logic [9:0]     tx_sh_r;
	logic           tx_bit_r;
	logic           tclk_r;
	logic           tx_clk_lvl;
	logic           pad_nxt;

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_sh_r       <= 10'h000;
			tx_bit_r      <= 1'b0;
			tx_word_taken <= 1'b0;
		end else begin
			tx_word_taken <= loc_word && tx_side && !tx_side_clear;
			if (bit_tick) begin
				tx_bit_r <= tx_sh_r[factor - 4'h1];
			end
			if (loc_word && tx_side_clear) begin
				tx_sh_r <= 10'h000; // [R14]
			end else if (loc_word) begin
				tx_sh_r <= tx_word & mask; // [R13] [R26]
			end else if (bit_tick) begin
				tx_sh_r <= {tx_sh_r[8:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tclk_r <= 1'b0;
		end else if (bit_tick) begin
			tclk_r <= !tclk_r;
		end
	end

	// Full rate gives one rising edge per bit, half rate one edge of either kind.
	assign tx_clk_lvl = half ? tclk_r : (bdiv_r == 8'h00); // [R24] [R22]
	assign pad_nxt    = clk_lane ? tx_clk_lvl : tx_bit_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			pad_p_o     <= 1'b0;
			pad_n_o     <= 1'b1;
			pad_oe      <= 1'b0;
			pad_rx_on   <= 1'b0;
			pad_term_on <= 1'b0;
			low_p_in    <= 1'b0;
			low_n_in    <= 1'b0;
		end else begin
			pad_p_o     <= low_on ? low_p_out : pad_nxt; // [R16]
			pad_n_o     <= low_on ? low_n_out : !pad_nxt; // [R16]
			pad_oe      <= pad_drive_on && tx_side; // [R27]
			pad_rx_on   <= rx_buffer_on && rx_side; // [R8]
			pad_term_on <= rx_side && (ctrl_r[DYN_POS] ? term_ctrl : ctrl_r[TERM_POS]); // [R9]
			low_p_in    <= pad_p_i; // [R16]
			low_n_in    <= pad_n_i;
		end
	end

	// ********************************************************************
	// Register port
	// ********************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
		end else if (reg_wr && reg_addr == CTRL_OFS) begin
			ctrl_r <= reg_wdata;
		end
	end

	always_comb begin
		stat_w = '0;
		stat_w[LOCK_POS]   = lock;
		stat_w[EMPTY_POS]  = queue_empty;
		stat_w[OVF_POS]    = ovf_r;
		stat_w[CFGERR_POS] = cfg_err;
		stat_w[RATEOK_POS] = rate_ok;
		stat_w[TAP_POS +: TAP_W]    = tap_r;
		stat_w[DPATAP_POS +: TAP_W] = dpa_tap_r;
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (rst || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			case (reg_addr)
				CTRL_OFS: begin
					reg_rdata <= ctrl_r;
				end
				STAT_OFS: begin
					reg_rdata <= stat_w;
				end
				WORD_OFS: begin
					reg_rdata <= {22'h000000, last_r};
				end
				default: begin
					reg_rdata <= '0;
				end
			endcase
		end
	end

endmodule

// *** verif/lane_chk.sv ***
`timescale 1ns/1ps
module lane_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Receive side
	input wire logic [9:0] rx_word,
	input wire logic       rx_word_valid,
	input wire logic       lock,
	input wire logic       queue_empty,
	input wire logic       queue_pop,
	input wire logic       rx_side_clear,
	input wire logic       rx_buffer_on,
	input wire logic       tap_adjust_on,
	// Transmit side and pads
	input wire logic       tx_word_taken,
	input wire logic       tx_side_clear,
	input wire logic       pad_drive_on,
	input wire logic       pad_p_o,
	input wire logic       pad_oe,
	input wire logic       pad_rx_on
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// A long clear must have flushed the serializer; counted, not repeated.
	logic [5:0] clr_cnt_r;
	always_ff @(posedge clk) begin
		if (rst || !tx_side_clear) begin
			clr_cnt_r <= 6'h00;
		end else if (clr_cnt_r != 6'h3F) begin
			clr_cnt_r <= clr_cnt_r + 6'h01;
		end
	end
	property p_oe;
		!$past(rst) |-> pad_oe == $past(pad_drive_on);
	endproperty
	a_oe: assert property (p_oe) else $error("pad enable off its input");
	property p_rxon;
		pad_rx_on |-> $past(rx_buffer_on);
	endproperty
	a_rxon: assert property (p_rxon) else $error("buffer on while off");
	property p_valid;
		rx_word_valid |=> !rx_word_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("word strobe too long");
	property p_hold;
		!rx_word_valid && !$past(rx_side_clear) && !$past(rst) |-> $stable(rx_word);
	endproperty
	a_hold: assert property (p_hold) else $error("word moved without strobe");
	property p_taken;
		tx_word_taken |=> !tx_word_taken [*8];
	endproperty
	a_taken: assert property (p_taken) else $error("transmit capture too soon");
	property p_pop;
		queue_pop && !queue_empty |=> rx_word_valid;
	endproperty
	a_pop: assert property (p_pop) else $error("pop gave no word");
	property p_clear;
		rx_side_clear ##1 rx_side_clear |-> queue_empty;
	endproperty
	a_clear: assert property (p_clear) else $error("queue not emptied");
	property p_lock;
		$rose(lock) |-> $past(tap_adjust_on);
	endproperty
	a_lock: assert property (p_lock) else $error("lock without training");
	property p_txclr;
		clr_cnt_r == 6'h3F |-> !pad_p_o;
	endproperty
	a_txclr: assert property (p_txclr) else $error("serializer not cleared");
	c_word: cover property (rx_word_valid);
	c_lock: cover property ($rose(lock));
	c_pop: cover property (queue_pop && !queue_empty);
	c_taken: cover property (tx_word_taken);
endmodule
bind lane_core lane_chk i_chk (.clk, .rst, .rx_word, .rx_word_valid, .lock, .queue_empty,
	.queue_pop, .rx_side_clear, .rx_buffer_on, .tap_adjust_on, .tx_word_taken,
	.tx_side_clear, .pad_drive_on, .pad_p_o, .pad_oe, .pad_rx_on);

// *** verif/far_end.sv ***
`timescale 1ns/1ps
module far_end #(
	parameter int BIT_DIV = 2
) (
	// Clock
	input  wire logic clk,
	// Level to send and line seen
	input  wire logic send_bit,
	output logic      seen_bit,
	// Pads
	input  wire logic pad_oe,
	input  wire logic pad_p_o,
	output logic      pad_p_i,
	output logic      pad_n_i
);
	int   cnt  = 0;
	logic hold = 1'b0;
	initial begin
		pad_p_i = 1'b0;
		pad_n_i = 1'b1;
		seen_bit = 1'b0;
	end
	// Each level stands a whole bit time, so words pass at bit rate over factor.
	always @(posedge clk) begin
		cnt <= (cnt + 1) % BIT_DIV;
		if (cnt == BIT_DIV - 1) begin
			hold <= send_bit;
		end
	end
	// While the lane drives, our line toggles every cycle and shows no stale level.
	always @(posedge clk) begin
		pad_p_i <= pad_oe ? ~pad_p_i : hold;
		pad_n_i <= pad_oe ? pad_p_i : ~hold;
		seen_bit <= pad_p_o;
	end
endmodule

// *** verif/differential_serdes_lane_tb_top.sv ***
`timescale 1ns/1ps
module differential_serdes_lane_tb_top;
	import lane_pkg::*;
	// ****
	// Bench signals
	// ****
	localparam int TAP_TOP = 3;
	logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, queue_pop = 1'b0;
	logic        rx_side_clear = 1'b0, rx_buffer_on = 1'b1, term_ctrl = 1'b0;
	logic        tap_adjust_on = 1'b0, tap_up_down = 1'b0, tap_clear = 1'b0;
	logic        tx_side_clear = 1'b0, pad_drive_on = 1'b0, send_bit = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
	logic [9:0]  tx_word = 10'h000, rx_word;
	logic        rx_word_valid, lock, queue_empty, tx_word_taken, seen_bit;
	logic        pad_p_i, pad_n_i, pad_p_o, pad_n_o, pad_oe, pad_rx_on, pad_term_on;
	int          fail_count = 0, check_count = 0, tap = 0, k, n;
	int          fac[4] = '{8, 10, 8, 10};

	// No data-lane mode receives here, so no foreign clock reaches the lane.
	lane_core #(.TAP_MAX(TAP_TOP), .LOCK_WORDS(2)) i_dut (
		.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.rx_word, .rx_word_valid, .lock, .queue_empty, .queue_pop, .rx_side_clear,
		.rx_buffer_on, .term_ctrl, .tap_adjust_on, .tap_up_down, .tap_clear,
		.tx_word, .tx_word_taken, .tx_side_clear, .pad_drive_on,
		.low_p_out(1'b0), .low_n_out(1'b0), .low_p_in(), .low_n_in(),
		.fwd_bit_tick(1'b0), .fwd_word_tick(1'b0), .lane_bit_clock(), .lane_word_clock(),
		.pad_p_i, .pad_n_i, .pad_p_o, .pad_n_o, .pad_oe, .pad_rx_on, .pad_term_on
	);
	far_end i_peer (.clk, .send_bit, .seen_bit, .pad_oe, .pad_p_o, .pad_p_i, .pad_n_i);

	initial begin
		forever #50 clk = ~clk;
	end

	// ****
	// Shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			fail_count++;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	// Every wait is bounded so that a silent lane ends the run.
	task automatic wait_ev(input int which);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			if ((which == 0 && rx_word_valid === 1'b1) || (which == 1 && tx_word_taken === 1'b1))
				return;
		end
		fail_count++;
		wrap_up();
	endtask

	// ****
	// Scenarios
	// ****
	initial begin
		void'($urandom(32'hC99B));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(CTRL_OFS); check(d, CTRL_RST);
		check(queue_empty, 1'b1);
		check(pad_oe, 1'b0);
		rd(STAT_OFS); check(d[4:3], 2'b10);
		rd(8'h0C); check(d, 32'h0000_0000);
		for (k = 0; k < 4; k++) begin
			n = $urandom;
			send_bit <= (k != 2);
			rx_buffer_on <= (k != 1);
			term_ctrl <= n[0];
			wr(CTRL_OFS, (CTRL_RST & 32'hFFFF_FFF0) | fac[k] | (32'h1 << DYN_POS));
			repeat (3) wait_ev(0);
			check(rx_word, (k == 1 || k == 2) ? 0 : (1 << fac[k]) - 1);
			check(pad_rx_on, k != 1);
			check(pad_term_on, n[0]);
		end
		rd(WORD_OFS); check(d, 32'h0000_03FF);
		for (k = 0; k < 3; k++) begin
			wait_ev(0);
			tap_up_down <= (k == 0);
			tap_adjust_on <= (k != 2);
			tap_clear <= (k == 2);
			n = (k == 0) ? 5 : 2;
			repeat (n) wait_ev(0);
			tap_adjust_on <= 1'b0;
			tap_clear <= 1'b0;
			if (k == 0) tap = (tap + n > TAP_TOP) ? TAP_TOP : tap + n;
			else tap = (k == 2 || tap < n) ? 0 : tap - n;
			rd(STAT_OFS); check(d[12:8], tap);
		end
		// Training on a steady line: lock after two clean words.
		wr(CTRL_OFS, CTRL_RST | (32'h1 << DPA_POS));
		tap_up_down <= 1'b1;
		tap_adjust_on <= 1'b1;
		for (n = 0; n < 8 && lock !== 1'b1; n++) wait_ev(0);
		check(n >= 2 && n <= 3, 1'b1);
		tap_clear <= 1'b1;
		repeat (2) wait_ev(0);
		tap_clear <= 1'b0;
		tap_adjust_on <= 1'b0;
		check(lock, 1'b0);
		rd(STAT_OFS); check(d[12:8], 0);
		wr(CTRL_OFS, CTRL_RST | (32'h1 << QUEUE_POS));
		repeat (120) @(posedge clk);
		check(queue_empty, 1'b0);
		rd(STAT_OFS); check(d[OVF_POS], 1'b1);
		queue_pop <= 1'b1;
		@(posedge clk);
		queue_pop <= 1'b0;
		wait_ev(0);
		check(rx_word, 10'h0FF);
		wr(STAT_OFS, 32'h1 << OVF_POS);
		rd(STAT_OFS); check(d[OVF_POS], 1'b0);
		rx_side_clear <= 1'b1;
		repeat (2) @(posedge clk);
		rx_side_clear <= 1'b0;
		@(posedge clk);
		check(queue_empty, 1'b1);
		wr(CTRL_OFS, CTRL_RST);
		pad_drive_on <= 1'b1;
		for (k = 0; k < 5; k++) begin
			n = $urandom;
			tx_side_clear <= (k == 4);
			tx_word <= {n[1:0], {8{n[2] | (k == 4)}}};
			// Under clear no capture is flagged, so cycles are counted instead.
			if (k == 4) repeat (100) @(posedge clk);
			else repeat (5) wait_ev(1);
			check(seen_bit, (k != 4) && n[2]);
			check(pad_n_o ^ pad_p_o, 1'b1);
		end
		tx_side_clear <= 1'b0;
		// A lane mode sends eight bits even when ten are asked for.
		wr(CTRL_OFS, (CTRL_RST & 32'hFFFF_FFF0) | 32'hA | (32'h1 << MODE_POS));
		tx_word <= 10'h300;
		repeat (2) wait_ev(1);
		d = 0;
		repeat (40) begin
			@(posedge clk);
			d = d | seen_bit;
		end
		check(d, 0);
		pad_drive_on <= 1'b0;
		repeat (2) @(posedge clk);
		check(pad_oe, 1'b0);
		wrap_up();
	end
endmodule
